/* rtl/pts_pkg.sv */
// shared constants, types and helpers of the pci target pin block
package pts_pkg;

   // bus commands that the target answers (address phase c/be lanes)
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;

   // word step of the burst address counter, in bytes
   localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

   // reset values of the pin drivers
   localparam logic OE_N_OFF  = 1'h1;   // driver floating
   localparam logic PIN_IDLE  = 1'h1;   // inactive level of low-true pins
   localparam logic PIN_ACT   = 1'h0;   // active level of low-true pins
   localparam logic [31:0] AD_RST = 32'h0000_0000;

   // bus state machine
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SKIP = 4'b0010,
      ST_DATA = 4'b0100,
      ST_TURN = 4'b1000
   } pts_state_t;

   // pci inputs as sampled once per pci clock
   typedef struct packed {
      logic        idsel;
      logic        irdy_n;
      logic        frame_n;
      logic        par;
      logic [3:0]  cbe_n;
      logic [31:0] ad;
   } pts_bus_t;

   // one write word handed to the back end
   typedef struct packed {
      logic        cfg;
      logic [3:0]  be;
      logic [31:0] data;
      logic [31:0] addr;
   } pts_wr_t;

   // even parity bit over address/data and command/byte enables
   function automatic logic pts_even_par(input logic [31:0] ad,
                                         input logic [3:0]  cbe_n);
      return ^{ad, cbe_n};
   endfunction

endpackage

/* rtl/pts_sync.sv */
// two-stage synchroniser bank for pins from the pci clock domain
`timescale 1ns/100ps
`default_nettype none
module pts_sync #(
   parameter int W = 1
)(
   input  wire logic         sys_clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] d_in,
   output var  logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   // resets to ones so low-true pins look idle until sampled
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= '1;
         q_out  <= '1;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;   // only reader of the first stage
      end
   end
endmodule
`default_nettype wire

/* rtl/pts_par_unit.sv */
// parity generation, parity checking and error pin timing
`timescale 1ns/100ps
`default_nettype none
module pts_par_unit (
   input  wire logic              sys_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              tick_in,
   input  wire pts_pkg::pts_bus_t bus_in,
   input  wire logic              ad_drv_in,
   input  wire logic [31:0]       ad_val_in,
   input  wire logic              chk_addr_in,
   input  wire logic              chk_data_in,
   input  wire logic              perr_en_in,
   output var  logic              par_out,
   output var  logic              par_oe_n_out,
   output var  logic              perr_n_out,
   output var  logic              perr_oe_n_out,
   output var  logic              serr_oe_n_out
);
   logic par_nxt, par_oe_n_nxt, perr_n_nxt, perr_oe_n_nxt, serr_oe_n_nxt;
   logic pend_a_r, pend_a_nxt, pend_d_r, pend_d_nxt, exp_r, exp_nxt;
   logic bad;

   // next values, all stepping on the pci clock tick
   always_comb begin
      par_nxt       = par_out;
      par_oe_n_nxt  = par_oe_n_out;
      perr_n_nxt    = perr_n_out;
      perr_oe_n_nxt = perr_oe_n_out;
      serr_oe_n_nxt = serr_oe_n_out;
      pend_a_nxt    = pend_a_r;
      pend_d_nxt    = pend_d_r;
      exp_nxt       = exp_r;
      bad           = (bus_in.par != exp_r);
      if (tick_in) begin
         // parity of the word we drove last clock, one clock late
         par_nxt      = pts_pkg::pts_even_par(ad_val_in, bus_in.cbe_n); // [RULE_06] [RULE_07]
         par_oe_n_nxt = ~ad_drv_in;                                   // [RULE_08]
         // remember what the master's parity must be next clock
         exp_nxt    = pts_pkg::pts_even_par(bus_in.ad, bus_in.cbe_n);   // [RULE_06]
         pend_a_nxt = chk_addr_in;
         pend_d_nxt = chk_data_in;
         // data error shows low two clocks after its phase
         perr_n_nxt    = ~(pend_d_r & bad);                           // [RULE_11]
         // a low perr is followed by one high clock before release
         perr_oe_n_nxt = ~(perr_en_in | (pend_d_r & bad) | ~perr_n_out); // [RULE_01]
         // system error only ever pulls low for one clock
         serr_oe_n_nxt = ~(pend_a_r & bad);                           // [RULE_14] [RULE_03]
      end
   end

   // register stage, floating all drivers under reset
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         par_out       <= pts_pkg::PIN_ACT;
         par_oe_n_out  <= pts_pkg::OE_N_OFF;    // [RULE_15]
         perr_n_out    <= pts_pkg::PIN_IDLE;
         perr_oe_n_out <= pts_pkg::OE_N_OFF;
         serr_oe_n_out <= pts_pkg::OE_N_OFF;
         pend_a_r      <= 1'h0;
         pend_d_r      <= 1'h0;
         exp_r         <= 1'h0;
      end else begin
         par_out       <= par_nxt;
         par_oe_n_out  <= par_oe_n_nxt;
         perr_n_out    <= perr_n_nxt;
         perr_oe_n_out <= perr_oe_n_nxt;
         serr_oe_n_out <= serr_oe_n_nxt;
         pend_a_r      <= pend_a_nxt;
         pend_d_r      <= pend_d_nxt;
         exp_r         <= exp_nxt;
      end
   end
endmodule
`default_nettype wire

/* rtl/pts_target.sv */
// pci target pin signalling: decode, handshake, turnaround, back end
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// (RULE_01) a released low-true control line is driven high for a clock first.
// (RULE_02) only one agent drives a low-true control line at a time.
// (RULE_03) open-drain lines are pulled low or released, never driven high.
// (RULE_04) the 32-bit ad bus carries the address, then data words.
// (RULE_05) c/be lanes carry the command, then per-byte enables.
// (RULE_06) parity makes the ones over ad, c/be and parity even.
// (RULE_07) parity trails the word it covers by one clock.
// (RULE_08) master gives address and write parity, target gives read parity.
// (RULE_09) the master holds frame low during a transaction, high to end it.
// (RULE_10) device select is asserted only on a decoded address hit.
// (RULE_11) a data parity error drives perr low two clocks after the phase.
// (RULE_12) a word moves only when both ready lines are low.
// (RULE_13) the target may assert stop to end a burst early.
// (RULE_14) an address parity error pulls the system error line low.
// (RULE_15) under reset all pci outputs float and the bus machine idles.
module pts_target #(
   parameter logic [31:0] BAR_BASE = 32'h8000_0000,
   parameter logic [31:0] BAR_MASK = 32'hffff_f000
)(
   input  wire logic            sys_clk_in,
   input  wire logic            rst_n_in,
   input  wire logic            pci_clk_in,
   input  wire logic [31:0]     ad_in,
   output var  logic [31:0]     ad_out,
   output var  logic            ad_oe_n_out,
   input  wire logic [3:0]      cbe_n_in,
   input  wire logic            par_in,
   output var  logic            par_out,
   output var  logic            par_oe_n_out,
   input  wire logic            frame_n_in,
   input  wire logic            irdy_n_in,
   input  wire logic            idsel_in,
   output var  logic            devsel_n_out,
   output var  logic            devsel_oe_n_out,
   output var  logic            trdy_n_out,
   output var  logic            trdy_oe_n_out,
   output var  logic            stop_n_out,
   output var  logic            stop_oe_n_out,
   output var  logic            perr_n_out,
   output var  logic            perr_oe_n_out,
   output var  logic            serr_n_out,
   output var  logic            serr_oe_n_out,
   output var  pts_pkg::pts_wr_t usr_wr_out,
   output var  logic            usr_wr_stb_out,
   output var  logic [31:0]     usr_rd_addr_out,
   output var  logic            usr_rd_cfg_out,
   output var  logic            usr_rd_stb_out,
   input  wire logic [31:0]     usr_rd_data_in,
   input  wire logic            usr_wait_in,
   input  wire logic            usr_stop_in
);
   localparam int SW = $bits(pts_pkg::pts_bus_t) + 1;

   logic [SW-1:0]     sync_q;
   pts_pkg::pts_bus_t bus;
   logic              clk_q, clk_d_r, tick;

   pts_pkg::pts_state_t state_r, state_nxt;
   logic        read_r, read_nxt, cfg_r, cfg_nxt, first_r, first_nxt;
   logic        frame_d_r, frame_d_nxt;
   logic [31:0] addr_r, addr_nxt, ad_r, ad_nxt;
   logic        devsel_r, devsel_nxt, trdy_r, trdy_nxt, stop_r, stop_nxt;
   logic        ctl_oe_n_r, ctl_oe_n_nxt, ad_oe_n_r, ad_oe_n_nxt;
   pts_pkg::pts_wr_t wr_r, wr_nxt;
   logic        wr_stb_r, wr_stb_nxt, rd_stb_r, rd_stb_nxt;
   logic        chk_addr, chk_data, xfer, hit, is_rd, is_mem, is_cfg;
   logic [3:0]  cmd;

   // every pci pin, the pci clock among them, crosses two flops first
   pts_sync #(
      .W (SW)
   ) u_sync (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .d_in       ({pci_clk_in, idsel_in, irdy_n_in, frame_n_in, par_in,
                    cbe_n_in, ad_in}),
      .q_out      (sync_q)
   );

   // all pins share one latency, so a tick sees a consistent bus
   assign clk_q = sync_q[SW-1];
   assign bus   = pts_pkg::pts_bus_t'(sync_q[SW-2:0]);
   assign tick  = clk_q & ~clk_d_r;

   // address phase decode of command and base address window
   assign cmd    = bus.cbe_n;                                        // [RULE_05]
   assign is_rd  = (cmd == pts_pkg::CMD_MEM_RD) |
                   (cmd == pts_pkg::CMD_CFG_RD);
   assign is_mem = ((cmd == pts_pkg::CMD_MEM_RD) |
                    (cmd == pts_pkg::CMD_MEM_WR)) &
                   ((bus.ad & BAR_MASK) == BAR_BASE);                // [RULE_04]
   assign is_cfg = ((cmd == pts_pkg::CMD_CFG_RD) |
                    (cmd == pts_pkg::CMD_CFG_WR)) &
                   bus.idsel & (bus.ad[1:0] == 2'h0);
   assign hit    = is_mem | is_cfg;

   // a word moves when both readies were low over the clock just ended
   assign xfer = (state_r == pts_pkg::ST_DATA) & ~bus.irdy_n &
                 ~trdy_r & ~ctl_oe_n_r;                              // [RULE_12]

   // bus state machine, stepping once per pci clock tick
   always_comb begin
      state_nxt    = state_r;
      read_nxt     = read_r;
      cfg_nxt      = cfg_r;
      first_nxt    = first_r;
      frame_d_nxt  = frame_d_r;
      addr_nxt     = addr_r;
      devsel_nxt   = devsel_r;
      trdy_nxt     = trdy_r;
      stop_nxt     = stop_r;
      ctl_oe_n_nxt = ctl_oe_n_r;
      ad_oe_n_nxt  = ad_oe_n_r;
      wr_nxt       = wr_r;
      wr_stb_nxt   = 1'h0;
      rd_stb_nxt   = 1'h0;
      chk_addr     = 1'h0;
      chk_data     = 1'h0;
      // read data follows the back end between ticks, settled by the edge
      ad_nxt       = read_r ? usr_rd_data_in : ad_r;
      if (tick) begin
         frame_d_nxt = bus.frame_n;
         case (state_r)
            pts_pkg::ST_IDLE: begin
               // falling frame marks the address phase
               if (~bus.frame_n & frame_d_r) begin                   // [RULE_09]
                  chk_addr = 1'h1;
                  if (hit) begin                                      // [RULE_10]
                     state_nxt    = pts_pkg::ST_DATA;
                     devsel_nxt   = pts_pkg::PIN_ACT;
                     trdy_nxt     = pts_pkg::PIN_IDLE;
                     stop_nxt     = pts_pkg::PIN_IDLE;
                     ctl_oe_n_nxt = 1'h0;                             // [RULE_02]
                     first_nxt    = 1'h1;
                     read_nxt     = is_rd;
                     cfg_nxt      = is_cfg;
                     addr_nxt     = {bus.ad[31:2], 2'h0};             // [RULE_04]
                  end else begin
                     state_nxt = pts_pkg::ST_SKIP;
                  end
               end
            end
            pts_pkg::ST_SKIP: begin
               // someone else's transaction: wait for an idle bus
               if (bus.frame_n & bus.irdy_n) begin
                  state_nxt = pts_pkg::ST_IDLE;
               end
            end
            pts_pkg::ST_DATA: begin
               first_nxt = 1'h0;
               if (xfer) begin
                  addr_nxt = addr_r + pts_pkg::ADDR_STEP;
                  if (read_r) begin
                     rd_stb_nxt = 1'h1;
                  end else begin
                     wr_stb_nxt  = 1'h1;
                     chk_data    = 1'h1;
                     wr_nxt.addr = addr_r;
                     wr_nxt.data = bus.ad;                            // [RULE_04]
                     wr_nxt.be   = ~bus.cbe_n;                        // [RULE_05]
                     wr_nxt.cfg  = cfg_r;
                  end
               end
               // end on the last word, after stop, or on master abort
               if (bus.frame_n & (xfer | ~stop_r | bus.irdy_n)) begin // [RULE_09]
                  state_nxt   = pts_pkg::ST_TURN;
                  devsel_nxt  = pts_pkg::PIN_IDLE;                    // [RULE_01]
                  trdy_nxt    = pts_pkg::PIN_IDLE;
                  stop_nxt    = pts_pkg::PIN_IDLE;
                  ad_oe_n_nxt = pts_pkg::OE_N_OFF;
               end else begin
                  // a word can still move in the first clock stop is out, none after it
                  stop_nxt    = stop_r & ~usr_stop_in;               // [RULE_13]
                  trdy_nxt    = usr_wait_in | ~stop_r;                // [RULE_12]
                  // first tick after the address is the ad turnaround
                  ad_oe_n_nxt = ~read_r;                              // [RULE_08]
               end
            end
            pts_pkg::ST_TURN: begin
               // lines were high for a full clock: now let them float
               ctl_oe_n_nxt = pts_pkg::OE_N_OFF;                     // [RULE_01]
               state_nxt    = pts_pkg::ST_IDLE;
            end
            default: begin
               state_nxt    = pts_pkg::ST_IDLE;
               ctl_oe_n_nxt = pts_pkg::OE_N_OFF;
               ad_oe_n_nxt  = pts_pkg::OE_N_OFF;
            end
         endcase
      end
   end

   // register stage; reset floats every driver and idles the machine
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clk_d_r    <= 1'h1;
         state_r    <= pts_pkg::ST_IDLE;                              // [RULE_15]
         read_r     <= 1'h0;
         cfg_r      <= 1'h0;
         first_r    <= 1'h0;
         frame_d_r  <= pts_pkg::PIN_IDLE;
         addr_r     <= pts_pkg::AD_RST;
         ad_r       <= pts_pkg::AD_RST;
         devsel_r   <= pts_pkg::PIN_IDLE;
         trdy_r     <= pts_pkg::PIN_IDLE;
         stop_r     <= pts_pkg::PIN_IDLE;
         ctl_oe_n_r <= pts_pkg::OE_N_OFF;                             // [RULE_15]
         ad_oe_n_r  <= pts_pkg::OE_N_OFF;
         wr_r       <= '0;
         wr_stb_r   <= 1'h0;
         rd_stb_r   <= 1'h0;
      end else begin
         clk_d_r    <= clk_q;
         state_r    <= state_nxt;
         read_r     <= read_nxt;
         cfg_r      <= cfg_nxt;
         first_r    <= first_nxt;
         frame_d_r  <= frame_d_nxt;
         addr_r     <= addr_nxt;
         ad_r       <= ad_nxt;
         devsel_r   <= devsel_nxt;
         trdy_r     <= trdy_nxt;
         stop_r     <= stop_nxt;
         ctl_oe_n_r <= ctl_oe_n_nxt;
         ad_oe_n_r  <= ad_oe_n_nxt;
         wr_r       <= wr_nxt;
         wr_stb_r   <= wr_stb_nxt;
         rd_stb_r   <= rd_stb_nxt;
      end
   end

   // parity and error pins; perr only while we receive write data
   pts_par_unit u_par (
      .sys_clk_in    (sys_clk_in),
      .rst_n_in      (rst_n_in),
      .tick_in       (tick),
      .bus_in        (bus),
      .ad_drv_in     (~ad_oe_n_r),
      .ad_val_in     (ad_r),
      .chk_addr_in   (chk_addr),
      .chk_data_in   (chk_data),
      .perr_en_in    (((state_r == pts_pkg::ST_DATA) |
                       (state_r == pts_pkg::ST_TURN)) & ~read_r),     // [RULE_02]
      .par_out       (par_out),
      .par_oe_n_out  (par_oe_n_out),
      .perr_n_out    (perr_n_out),
      .perr_oe_n_out (perr_oe_n_out),
      .serr_oe_n_out (serr_oe_n_out)
   );

   // the three control lines share one enable: they turn round together
   assign devsel_n_out    = devsel_r;
   assign trdy_n_out      = trdy_r;
   assign stop_n_out      = stop_r;
   assign devsel_oe_n_out = ctl_oe_n_r;
   assign trdy_oe_n_out   = ctl_oe_n_r;
   assign stop_oe_n_out   = ctl_oe_n_r;
   assign ad_out          = ad_r;
   assign ad_oe_n_out     = ad_oe_n_r;
   assign serr_n_out      = pts_pkg::PIN_ACT;   // open drain: low or off [RULE_03]
   assign usr_wr_out      = wr_r;
   assign usr_wr_stb_out  = wr_stb_r;
   assign usr_rd_addr_out = addr_r;
   assign usr_rd_cfg_out  = cfg_r;
   assign usr_rd_stb_out  = rd_stb_r;
endmodule
`default_nettype wire

/* test/pts_target_props.sv */
// pin-side timing checks of the pci target, bound onto its ports
`timescale 1ns/100ps
`default_nettype none
module pts_target_props (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic ad_oe_n_out,
   input  wire logic par_oe_n_out,
   input  wire logic devsel_n_out,
   input  wire logic devsel_oe_n_out,
   input  wire logic trdy_n_out,
   input  wire logic trdy_oe_n_out,
   input  wire logic stop_n_out,
   input  wire logic perr_n_out,
   input  wire logic perr_oe_n_out,
   input  wire logic serr_n_out,
   input  wire logic serr_oe_n_out,
   input  wire logic usr_wr_stb_out,
   input  wire logic usr_rd_stb_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // drive steps of the read path and the control release
   sequence ad_drive_s;  $fell(ad_oe_n_out);  endsequence
   sequence par_drive_s; $fell(par_oe_n_out); endsequence
   sequence ctl_free_s;  $rose(devsel_oe_n_out); endsequence
   // one pci clock is eight system clocks in every bench run
   float_rst_a: assert property ($rose(rst_n_in) |-> ad_oe_n_out &&
      par_oe_n_out && devsel_oe_n_out && perr_oe_n_out && serr_oe_n_out)
      else $error("pin driven right after reset");
   rel_high_a: assert property (ctl_free_s |-> $past(devsel_n_out, 4) &&
      $past(trdy_n_out, 4) && $past(stop_n_out, 4) &&
      !$past(devsel_oe_n_out, 4)) else $error("control released while low");
   serr_od_a: assert property (serr_n_out == 1'h0)
      else $error("system error pin driven high");
   trdy_sel_a: assert property (!trdy_n_out && !trdy_oe_n_out |->
      !devsel_n_out) else $error("target ready without device select");
   par_lag_a: assert property (ad_drive_s |-> ##[7:9] par_drive_s)
      else $error("read parity not one pci clock after data");
   perr_wid_a: assert property ($fell(perr_n_out) |->
      (!perr_oe_n_out && !perr_n_out)[*7] ##[1:2] perr_n_out)
      else $error("parity error pulse has wrong width");
   serr_wid_a: assert property ($fell(serr_oe_n_out) |->
      (!serr_oe_n_out)[*7] ##[1:2] serr_oe_n_out)
      else $error("system error pulse has wrong width");
   word_move_a: assert property (usr_wr_stb_out || usr_rd_stb_out |->
      !$past(trdy_n_out, 4) && !$past(devsel_n_out, 4))
      else $error("word moved without target ready");
endmodule
bind pts_target pts_target_props chk_u (.sys_clk_in, .rst_n_in, .ad_oe_n_out,
   .par_oe_n_out, .devsel_n_out, .devsel_oe_n_out, .trdy_n_out,
   .trdy_oe_n_out, .stop_n_out, .perr_n_out, .perr_oe_n_out, .serr_n_out,
   .serr_oe_n_out, .usr_wr_stb_out, .usr_rd_stb_out);
`default_nettype wire

/* test/pts_master.sv */
// pci bus master model that runs single-word transactions
`timescale 1ns/100ps
`default_nettype none
module pts_master (
   input  wire logic        pci_clk_in,
   input  wire logic [31:0] t_ad_in,
   input  wire logic        t_ad_oe_n_in,
   input  wire logic        t_par_in,
   input  wire logic        t_par_oe_n_in,
   input  wire logic        devsel_n_in,
   input  wire logic        devsel_oe_n_in,
   input  wire logic        trdy_n_in,
   input  wire logic        trdy_oe_n_in,
   input  wire logic        stop_n_in,
   input  wire logic        stop_oe_n_in,
   input  wire logic        perr_n_in,
   input  wire logic        perr_oe_n_in,
   input  wire logic        serr_oe_n_in,
   output var  logic [31:0] ad_out,
   output var  logic [3:0]  cbe_n_out,
   output var  logic        par_out,
   output var  logic        frame_n_out,
   output var  logic        irdy_n_out,
   output var  logic        idsel_out
);
   logic [31:0] ad_r, rd_data;
   logic [3:0]  cbe_r;
   logic [2:0]  perr_hist;
   logic        par_r, frame_r, irdy_r, fi_oe, ad_oe, par_oe, flip;
   logic        rd_par, dev_low, stop_low, serr_low, moved;
   int          n_wait;
   initial begin
      {fi_oe, ad_oe, par_oe, flip, idsel_out} = 5'h00;
      {frame_r, irdy_r} = 2'h3;
   end
   // released lines toggle each clock so stale data never matches
   always @(posedge pci_clk_in) flip <= ~flip;
   // one driver per line; pulled-up lines read high when released
   assign ad_out = !t_ad_oe_n_in ? t_ad_in : ad_oe ? ad_r : {32{flip}};
   assign par_out = !t_par_oe_n_in ? t_par_in : par_oe ? par_r : flip;
   assign cbe_n_out = fi_oe ? cbe_r : {4{flip}};
   assign frame_n_out = fi_oe ? frame_r : 1'h1;
   assign irdy_n_out = fi_oe ? irdy_r : 1'h1;
   // single-word transfer; results left in the variables above
   task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
      input logic [31:0] dat, input logic [3:0] be, input logic sel,
      input logic bad_a, input logic bad_d);
      {dev_low, stop_low, serr_low, moved, n_wait} = '0;
      repeat (2) @(posedge pci_clk_in);
      fi_oe <= 1'h1; frame_r <= 1'h0; ad_oe <= 1'h1;
      ad_r <= addr; cbe_r <= cmd; idsel_out <= sel;
      @(posedge pci_clk_in);
      par_oe <= 1'h1; par_r <= ^{addr, cmd} ^ bad_a;
      frame_r <= 1'h1; irdy_r <= 1'h0; cbe_r <= ~be;
      idsel_out <= 1'h0; ad_oe <= cmd[0]; ad_r <= dat;
      do begin
         @(posedge pci_clk_in);
         n_wait++;
         dev_low |= !(devsel_oe_n_in | devsel_n_in);
         stop_low |= !(stop_oe_n_in | stop_n_in);
         serr_low |= !serr_oe_n_in;
         moved = !(trdy_oe_n_in | trdy_n_in);
         rd_data = ad_out;
         par_oe <= cmd[0]; par_r <= ^{dat, ~be} ^ bad_d;
      end while (!moved && !stop_low && n_wait < 8);
      irdy_r <= 1'h1; ad_oe <= 1'h0;
      for (int i = 0; i < 3; i++) begin
         @(posedge pci_clk_in);
         if (i == 0) rd_par = par_out;
         perr_hist[i] = perr_oe_n_in | perr_n_in;
         serr_low |= !serr_oe_n_in;
         fi_oe <= 1'h0; par_oe <= 1'h0;
      end
   endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the pci target pin block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic             sys_clk, rst_n, pci_clk, pci_clk_d, wait_r, stop_r;
   logic [31:0]      ad_m, ad_t, rd_addr;
   logic [3:0]       cbe_n;
   logic             par_m, par_t, frame_n, irdy_n, idsel, ad_oe_n, par_oe_n;
   logic             devsel_n, devsel_oe_n, trdy_n, trdy_oe_n, stop_n;
   logic             stop_oe_n, perr_n, perr_oe_n, serr_n, serr_oe_n;
   logic             wr_stb, rd_stb, rd_cfg;
   pts_pkg::pts_wr_t wr_word, wr_cap;
   int               fail_count, cmp_count, wr_cnt;
   pts_target dut_u (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .ad_in(ad_m),
      .pci_clk_in(pci_clk), .ad_out(ad_t), .ad_oe_n_out(ad_oe_n),
      .cbe_n_in(cbe_n), .par_in(par_m), .par_out(par_t),
      .par_oe_n_out(par_oe_n), .frame_n_in(frame_n), .irdy_n_in(irdy_n),
      .idsel_in(idsel), .devsel_n_out(devsel_n), .devsel_oe_n_out(devsel_oe_n),
      .trdy_n_out(trdy_n), .trdy_oe_n_out(trdy_oe_n), .stop_n_out(stop_n),
      .stop_oe_n_out(stop_oe_n), .perr_n_out(perr_n), .serr_n_out(serr_n),
      .perr_oe_n_out(perr_oe_n), .serr_oe_n_out(serr_oe_n),
      .usr_wr_out(wr_word), .usr_wr_stb_out(wr_stb), .usr_rd_stb_out(rd_stb),
      .usr_rd_addr_out(rd_addr), .usr_rd_cfg_out(rd_cfg),
      .usr_rd_data_in(rd_addr ^ 32'h0f0f_0f0f), .usr_wait_in(wait_r),
      .usr_stop_in(stop_r));
   pts_master m_u (.pci_clk_in(pci_clk_d), .t_ad_in(ad_t), .t_par_in(par_t),
      .t_ad_oe_n_in(ad_oe_n), .t_par_oe_n_in(par_oe_n),
      .devsel_n_in(devsel_n), .devsel_oe_n_in(devsel_oe_n),
      .trdy_n_in(trdy_n), .trdy_oe_n_in(trdy_oe_n), .stop_n_in(stop_n),
      .stop_oe_n_in(stop_oe_n), .perr_n_in(perr_n), .perr_oe_n_in(perr_oe_n),
      .serr_oe_n_in(serr_oe_n), .ad_out(ad_m), .cbe_n_out(cbe_n),
      .par_out(par_m), .frame_n_out(frame_n), .irdy_n_out(irdy_n),
      .idsel_out(idsel));
   // system clock, and a free pci clock offset so edges never coincide
   initial begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      pci_clk = 1'h0;
      #7;
      forever #80 pci_clk = ~pci_clk;
   end
   // master pins trail its edge like real drivers, so ticks see old values
   assign #5 pci_clk_d = pci_clk;
   // keep the last write word handed to the back end
   always @(posedge sys_clk) if (wr_stb === 1'h1) begin
      wr_cap <= wr_word;
      wr_cnt <= wr_cnt + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // every command once, all of them claimed
   task automatic t_cmds;
      logic [3:0]  cmds [4];
      logic [31:0] a, d;
      int          n;
      cmds = '{pts_pkg::CMD_MEM_RD, pts_pkg::CMD_MEM_WR,
               pts_pkg::CMD_CFG_RD, pts_pkg::CMD_CFG_WR};
      for (int i = 0; i < 4; i++) begin
         a = cmds[i][3] ? 32'h0000_0010 : 32'h8000_0040;
         d = 32'hc3a5_1e70 + i;
         n = wr_cnt;
         m_u.xfer(cmds[i], a, d, 4'ha, cmds[i][3], 1'h0, 1'h0);
         chk(m_u.dev_low, 1'h1);
         chk({m_u.serr_low, m_u.perr_hist}, 4'h7);
         if (cmds[i][0]) begin
            chk(wr_cnt, n + 1);
            chk(wr_cap.data, d);
            chk(wr_cap.addr, a);
            chk({wr_cap.cfg, wr_cap.be}, {cmds[i][3], 4'ha});
         end else begin
            d = a ^ 32'h0f0f_0f0f;
            chk(m_u.rd_data, d);
            chk(rd_cfg, cmds[i][3]);
            chk(m_u.rd_par, ^{d, 4'h5});
         end
      end
   endtask
   // a miss is never claimed, then wait states at the last word of the window
   task automatic t_miss_wait;
      int n;
      n = wr_cnt;
      m_u.xfer(pts_pkg::CMD_MEM_WR, 32'h8000_1000, 32'h1234_5678, 4'hf,
               1'h0, 1'h0, 1'h0);
      chk({m_u.dev_low, m_u.moved}, 2'h0);
      chk(wr_cnt, n);
      @(posedge sys_clk);
      wait_r <= 1'h1;
      fork
         m_u.xfer(pts_pkg::CMD_MEM_WR, 32'h8000_0ffc, 32'h0bad_cafe, 4'h3,
                  1'h0, 1'h0, 1'h0);
         begin
            repeat (64) @(posedge sys_clk);
            wait_r <= 1'h0;
         end
      join
      chk(m_u.moved, 1'h1);
      chk(m_u.n_wait > 2, 1'h1);
      chk(wr_cap.addr, 32'h8000_0ffc);
   endtask
   // bad data parity, then bad address parity
   task automatic t_parity;
      m_u.xfer(pts_pkg::CMD_MEM_WR, 32'h8000_0100, 32'h0000_0001, 4'hf,
               1'h0, 1'h0, 1'h1);
      chk({m_u.serr_low, m_u.perr_hist}, 4'h5);
      m_u.xfer(pts_pkg::CMD_MEM_WR, 32'h8000_0104, 32'h0000_0003, 4'hf,
               1'h0, 1'h1, 1'h0);
      chk(m_u.serr_low, 1'h1);
   endtask
   // back end asks for stop before any word moves
   task automatic t_stop;
      @(posedge sys_clk);
      {wait_r, stop_r} <= 2'h3;
      m_u.xfer(pts_pkg::CMD_MEM_RD, 32'h8000_0200, 32'h0000_0000, 4'hf,
               1'h0, 1'h0, 1'h0);
      chk({m_u.stop_low, m_u.moved}, 2'h2);
      @(posedge sys_clk);
      {wait_r, stop_r} <= 2'h0;
   endtask
   // main sequence
   initial begin
      {rst_n, wait_r, stop_r, wr_cnt} = '0;
      repeat (3) @(posedge sys_clk);
      chk({ad_oe_n, par_oe_n, devsel_oe_n, perr_oe_n, serr_oe_n}, 5'h1f);
      rst_n <= 1'h1;
      t_cmds;
      t_miss_wait;
      t_parity;
      t_stop;
      print_verdict;
   end
   // watchdog against a hung handshake
   initial begin
      #200_000;
      fail_count++;
      print_verdict;
   end
endmodule
`default_nettype wire
